// [pllcg_pkg.sv]
// package: register map, field layout, strap table and counts of the clock mode generator
package pllcg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [31:0] PLLCG_ADDR_CLK_MODE = 32'h0000_0058;
   localparam logic [15:0] PLLCG_CFG_RESET = 16'h0000;
   localparam logic [15:0] PLLCG_CFG_WR_MASK = 16'hfffe;

   // field positions of clock_mode_config
   localparam int PLLCG_MUL_HI = 15;
   localparam int PLLCG_MUL_LO = 12;
   localparam int PLLCG_HALF_BIT = 11;
   localparam int PLLCG_CNT_HI = 10;
   localparam int PLLCG_CNT_LO = 3;
   localparam int PLLCG_LOOP_ON_BIT = 2;
   localparam int PLLCG_PLL_SEL_BIT = 1;
   localparam int PLLCG_LOCKED_BIT = 0;
   localparam logic [3:0] PLLCG_MUL_UNITY = 4'hf;

   // strap reset values
   localparam logic [15:0] PLLCG_RST_X10 = 16'h9007;
   localparam logic [15:0] PLLCG_RST_X5 = 16'h4007;
   localparam logic [15:0] PLLCG_RST_X2 = 16'h1007;
   localparam logic [15:0] PLLCG_RST_X1 = 16'hf007;
   localparam logic [15:0] PLLCG_RST_DIV2 = 16'h0000;
   localparam logic [15:0] PLLCG_RST_DIV4 = 16'hf000;
   localparam logic [2:0] PLLCG_STRAP_BYPASS = 3'h3;

   // lock timer: reference cycles per step of the count field
   localparam logic [12:0] PLLCG_LOCK_STEP = 13'h0010;
   localparam int PLLCG_LOCK_SHIFT = 4;
   localparam logic [1:0] PLLCG_DIV2_LAST = 2'h1;
   localparam logic [1:0] PLLCG_DIV4_LAST = 2'h3;
   localparam logic [15:0] PLLCG_PERIOD_MAX = 16'hffff;

   // number of pins passed through synchronisers
   localparam int PLLCG_NSYNC = 5;

   typedef enum logic [2:0] {
      PLLCG_ST_DIV = 3'b001,
      PLLCG_ST_LOCKING = 3'b010,
      PLLCG_ST_PLL = 3'b100
   } pllcg_state_t;

endpackage : pllcg_pkg

// [pllcg_rate_gen.sv]
// rate generator: num/den enables per measured reference period
`timescale 1ns/1ps
`default_nettype none
module pllcg_rate_gen
   import pllcg_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // control
   input wire logic i_run,
   input wire logic [15:0] i_period,
   input wire logic [4:0] i_num,
   input wire logic [1:0] i_den,
   // output
   output logic o_pulse
);

   logic [17:0] thresh;
   logic [17:0] acc_reg;
   logic [17:0] sum;
   logic pulse_reg;

   ////////////////////////////////////////////////////////////////////////////
   // phase accumulator: adds num each cycle, wraps at den*period
   // limitation: no more than one enable per system clock
   assign thresh = 18'(i_period) * 18'(i_den);
   assign sum = acc_reg + 18'(i_num);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         acc_reg <= 18'h0;
         pulse_reg <= 1'b0;
      end else if (!i_run) begin
         acc_reg <= 18'h0;
         pulse_reg <= 1'b0;
      end else if (sum >= thresh) begin
         acc_reg <= sum - thresh;
         pulse_reg <= 1'b1;
      end else begin
         acc_reg <= sum;
         pulse_reg <= 1'b0;
      end
   end

   assign o_pulse = pulse_reg;

endmodule : pllcg_rate_gen
`default_nettype wire

// [pllcg_top.sv]
// clock mode generator: strap-loaded mode register, divider, multiplier and lock timer
//
// Notes on behaviour
// - divider mode makes core enables from the reference divided by two or four, loop unused.
// - loop mode multiplies the reference rate by a programmed factor.
// - the factor takes one of 31 distinct ratios.
// - a started loop passes a lock-acquisition phase before counting as locked.
// - a locked loop keeps tracking the reference period and drives the core enable.
// - a lock timer holds the switch to loop clocking until lock.
// - software turns the loop on and off through the mode register.
// - divider mode divides the reference by two or four.
// - in divider mode the loop may be powered fully off.
// - configuration sits in a 16-bit register at byte address 0x58.
// - during reset the mode register loads a value set only by straps.
// - straps 001,010,100,110 load 9007h,4007h,1007h,F007h: x10,x5,x2,x1.
// - straps 000,111 load 0000h; 101 loads F000h; 011 is bypass.
// - straps are sampled while the device reset pin is low.
// - after reset a software write reconfigures the clock mode.
`timescale 1ns/1ps
`default_nettype none
module pllcg_top
   import pllcg_pkg::*;
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_NRST,
   // ahb-lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   output logic [31:0] O_HRDATA,
   // pins
   input wire logic I_REF_CLK,
   input wire logic I_DEVICE_RESET_N,
   input wire logic I_MODE_STRAP_A,
   input wire logic I_MODE_STRAP_B,
   input wire logic I_MODE_STRAP_C,
   // clock outputs
   output logic O_CORE_CLK_EN,
   output logic O_LOOP_POWER_EN,
   output logic O_LOCKED
);

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // strap code {a,b,c} to mode register value
   function automatic logic [15:0] strap_value(input logic [2:0] code);
      logic [15:0] v;
      v = PLLCG_RST_DIV2;
      case (code)
         3'h1: v = PLLCG_RST_X10;
         3'h2: v = PLLCG_RST_X5;
         3'h4: v = PLLCG_RST_X2;
         3'h6: v = PLLCG_RST_X1;
         3'h5: v = PLLCG_RST_DIV4;
         default: v = PLLCG_RST_DIV2;
      endcase
      return v;
   endfunction : strap_value

   // ratio numerator: half=0 gives 1..15 (mul 15 is x1), half=1 gives 0.5..15.5
   function automatic logic [4:0] ratio_num(input logic [3:0] mul, input logic half);
      logic [4:0] n;
      n = 5'h0;
      if (half) begin
         n = {mul, 1'b1};
      end else if (mul == PLLCG_MUL_UNITY) begin
         n = 5'h1;
      end else begin
         n = 5'({1'b0, mul} + 5'h1);
      end
      return n;
   endfunction : ratio_num

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [PLLCG_NSYNC-1:0] pin_in;
   logic [PLLCG_NSYNC-1:0] sync1_reg;
   logic [PLLCG_NSYNC-1:0] sync2_reg;

   assign pin_in = {I_REF_CLK, I_DEVICE_RESET_N, I_MODE_STRAP_A, I_MODE_STRAP_B,
                    I_MODE_STRAP_C};

   generate
      for (genvar g = 0; g < PLLCG_NSYNC; g++) begin : g_sync
         always_ff @(posedge I_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
               sync1_reg[g] <= 1'b0;
               sync2_reg[g] <= 1'b0;
            end else begin
               sync1_reg[g] <= pin_in[g];
               sync2_reg[g] <= sync1_reg[g];
            end
         end
      end
   endgenerate

   logic ref_s;
   logic dev_rst;
   logic [2:0] strap_s;
   logic ref_prev_reg;
   logic ref_rise;

   assign ref_s = sync2_reg[4];
   assign dev_rst = ~sync2_reg[3];
   assign strap_s = sync2_reg[2:0];
   assign ref_rise = ref_s & ~ref_prev_reg;

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ref_prev_reg <= 1'b0;
      end else begin
         ref_prev_reg <= ref_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states, always okay

   logic addr_ok;
   logic addr_hit;
   logic wr_pend_reg;
   logic [15:0] cfg_reg;
   logic bypass_reg;
   logic [15:0] cfg_rd;
   logic [31:0] hrdata_reg;
   logic cfg_wr;
   logic mul_changed;
   pllcg_state_t state_reg;

   assign addr_ok = I_HSEL & I_HTRANS[1] & I_HREADY;
   assign addr_hit = (I_HADDR == PLLCG_ADDR_CLK_MODE) && (I_HSIZE == 3'h2);
   // writes are dropped while the device reset pin holds the straps in charge
   assign cfg_wr = wr_pend_reg & ~dev_rst;
   assign mul_changed = cfg_wr &&
      (I_HWDATA[PLLCG_MUL_HI:PLLCG_HALF_BIT] != cfg_reg[PLLCG_MUL_HI:PLLCG_HALF_BIT]);
   assign cfg_rd = {cfg_reg[15:1], state_reg == PLLCG_ST_PLL};

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         wr_pend_reg <= 1'b0;
      end else if (I_HREADY) begin
         wr_pend_reg <= addr_ok & addr_hit & I_HWRITE;
      end
   end

   // read data sampled in the address phase; forwarding covers a write just before
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         hrdata_reg <= 32'h0;
      end else if (addr_ok) begin
         if (!addr_hit || I_HWRITE) begin
            hrdata_reg <= 32'h0;
         end else if (cfg_wr) begin
            hrdata_reg <= {16'h0, (I_HWDATA[15:0] & PLLCG_CFG_WR_MASK) |
                           {15'h0, state_reg == PLLCG_ST_PLL}};
         end else begin
            hrdata_reg <= {16'h0, cfg_rd};
         end
      end
   end

   assign O_HREADYOUT = 1'b1;
   assign O_HRESP = 1'b0;
   assign O_HRDATA = hrdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // mode register: straps while device reset is low, software after

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         cfg_reg <= PLLCG_CFG_RESET;
         bypass_reg <= 1'b0;
      end else if (dev_rst) begin
         cfg_reg <= strap_value(strap_s);
         bypass_reg <= (strap_s == PLLCG_STRAP_BYPASS);
      end else if (cfg_wr) begin
         cfg_reg <= I_HWDATA[15:0] & PLLCG_CFG_WR_MASK;
         bypass_reg <= 1'b0;
      end
   end

   logic loop_on;
   logic want_pll;
   logic [3:0] mul;
   logic half;

   assign mul = cfg_reg[PLLCG_MUL_HI:PLLCG_MUL_LO];
   assign half = cfg_reg[PLLCG_HALF_BIT];
   assign loop_on = cfg_reg[PLLCG_LOOP_ON_BIT];
   assign want_pll = loop_on & cfg_reg[PLLCG_PLL_SEL_BIT] & ~bypass_reg;

   ////////////////////////////////////////////////////////////////////////////
   // reference divider

   logic [1:0] div_cnt_reg;
   logic [1:0] div_last;
   logic div_pulse;

   // divide by four when the multiplier field is all ones and the pll select bit is clear
   assign div_last = (mul == PLLCG_MUL_UNITY && !cfg_reg[PLLCG_PLL_SEL_BIT]) ?
                     PLLCG_DIV4_LAST : PLLCG_DIV2_LAST;
   assign div_pulse = ref_rise && (div_cnt_reg >= div_last);

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         div_cnt_reg <= 2'h0;
      end else if (div_pulse || dev_rst) begin
         div_cnt_reg <= 2'h0;
      end else if (ref_rise) begin
         div_cnt_reg <= div_cnt_reg + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reference period meter: the loop's view of its input

   logic [15:0] per_cnt_reg;
   logic [15:0] period_reg;
   logic period_ok_reg;
   logic loop_pwr;

   assign loop_pwr = loop_on | (state_reg != PLLCG_ST_DIV);

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         per_cnt_reg <= 16'h0;
         period_reg <= 16'h0;
         period_ok_reg <= 1'b0;
      end else if (!loop_pwr) begin
         per_cnt_reg <= 16'h0;
         period_ok_reg <= 1'b0;
      end else if (ref_rise) begin
         per_cnt_reg <= 16'h1;
         if (per_cnt_reg != 16'h0) begin
            period_reg <= per_cnt_reg;
            period_ok_reg <= 1'b1;
         end
      end else if (per_cnt_reg != PLLCG_PERIOD_MAX && per_cnt_reg != 16'h0) begin
         per_cnt_reg <= per_cnt_reg + 16'h1;
      end
   end

   logic dds_pulse;

   pllcg_rate_gen u_rate (
      .i_clk(I_CLK),
      .i_nrst(I_NRST),
      .i_run(period_ok_reg & (state_reg != PLLCG_ST_DIV)),
      .i_period(period_reg),
      .i_num(ratio_num(mul, half)),
      .i_den(half ? 2'h2 : 2'h1),
      .o_pulse(dds_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // lock timer and source selection

   logic [12:0] lock_cnt_reg;
   logic [12:0] lock_target;
   logic lock_done;
   logic relock_reg;

   assign lock_target = 13'({5'h0, cfg_reg[PLLCG_CNT_HI:PLLCG_CNT_LO]} + 13'h1)
                        << PLLCG_LOCK_SHIFT;
   assign lock_done = (lock_cnt_reg >= lock_target) && period_ok_reg;

   // a multiplier change while locked forces a fresh lock phase
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         relock_reg <= 1'b0;
      end else if (mul_changed) begin
         relock_reg <= 1'b1;
      end else if (state_reg != PLLCG_ST_PLL) begin
         relock_reg <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state_reg <= PLLCG_ST_DIV;
         lock_cnt_reg <= 13'h0;
      end else if (dev_rst) begin
         state_reg <= PLLCG_ST_DIV;
         lock_cnt_reg <= 13'h0;
      end else begin
         case (state_reg)
            PLLCG_ST_DIV: begin
               lock_cnt_reg <= 13'h0;
               if (want_pll) begin
                  state_reg <= PLLCG_ST_LOCKING;
               end
            end
            PLLCG_ST_LOCKING: begin
               if (!want_pll) begin
                  state_reg <= PLLCG_ST_DIV;
               end else if (mul_changed) begin
                  lock_cnt_reg <= 13'h0;
               end else if (lock_done && div_pulse) begin
                  state_reg <= PLLCG_ST_PLL;
               end else if (ref_rise && !lock_done) begin
                  lock_cnt_reg <= lock_cnt_reg + 13'h1;
               end
            end
            PLLCG_ST_PLL: begin
               if ((!want_pll || relock_reg) && dds_pulse) begin
                  lock_cnt_reg <= 13'h0;
                  state_reg <= want_pll ? PLLCG_ST_LOCKING : PLLCG_ST_DIV;
               end
            end
            default: begin
               state_reg <= PLLCG_ST_DIV;
               lock_cnt_reg <= 13'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs: one source at a time, loop switched in or out right after a pulse except on device reset

   logic core_en_reg;
   logic loop_pwr_reg;
   logic locked_reg;

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         core_en_reg <= 1'b0;
         loop_pwr_reg <= 1'b0;
         locked_reg <= 1'b0;
      end else begin
         if (state_reg == PLLCG_ST_PLL) begin
            core_en_reg <= dds_pulse;
         end else if (bypass_reg) begin
            core_en_reg <= ref_rise;
         end else begin
            core_en_reg <= div_pulse;
         end
         loop_pwr_reg <= loop_pwr;
         locked_reg <= (state_reg == PLLCG_ST_PLL);
      end
   end

   assign O_CORE_CLK_EN = core_en_reg;
   assign O_LOOP_POWER_EN = loop_pwr_reg;
   assign O_LOCKED = locked_reg;

endmodule : pllcg_top
`default_nettype wire

// [pllcg_checker.sv]
// checker: bus, lock and divider relations at the ports of the clock mode generator
`timescale 1ns/1ps
`default_nettype none
module pllcg_checker (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_NRST,
   // bus
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic I_HREADY,
   input wire logic O_HREADYOUT,
   input wire logic O_HRESP,
   input wire logic [31:0] O_HRDATA,
   // pins and clock outputs
   input wire logic I_DEVICE_RESET_N,
   input wire logic O_CORE_CLK_EN,
   input wire logic O_LOOP_POWER_EN,
   input wire logic O_LOCKED
);
   // sixteen reference edges, each at least eight clocks apart
   localparam int LOCK_MIN = 128;
   logic [7:0] pwr_cnt_reg;
   wire logic take = I_HSEL && I_HTRANS[1] && I_HREADY;
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) pwr_cnt_reg <= 8'h00;
      else if (!O_LOOP_POWER_EN) pwr_cnt_reg <= 8'h00;
      else if (pwr_cnt_reg != 8'hff) pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);
   sequence bad_read;
      take && !I_HWRITE && (I_HADDR != 32'h58 || I_HSIZE != 3'h2);
   endsequence
   sequence dev_rst_held;
      (!I_DEVICE_RESET_N) [*5];
   endsequence
   sequence div_only_pulse;
      O_CORE_CLK_EN && !O_LOCKED && !O_LOOP_POWER_EN;
   endsequence
   AST_BUS_OKAY: assert property (O_HREADYOUT && !O_HRESP)
      else $error("bus answer not ready and okay");
   AST_RDATA_HIGH: assert property (O_HRDATA[31:16] == 16'h0000)
      else $error("upper read half not zero");
   AST_UNMAPPED_ZERO: assert property (bad_read |=> O_HRDATA == 32'h0)
      else $error("unmapped read not zero");
   AST_RDATA_STANDS: assert property (!take |=> $stable(O_HRDATA))
      else $error("read data moved without a request");
   AST_LOCK_POWER: assert property (O_LOCKED |-> O_LOOP_POWER_EN)
      else $error("locked while loop unpowered");
   AST_DEVRST_UNLOCKED: assert property (dev_rst_held |-> !O_LOCKED)
      else $error("locked during device reset");
   AST_DIV_SPACING: assert property (div_only_pulse |=> !O_CORE_CLK_EN [*3])
      else $error("divider pulses too close");
   AST_LOCK_WAIT: assert property ($rose(O_LOCKED) |-> pwr_cnt_reg >= LOCK_MIN)
      else $error("lock came too early");
endmodule : pllcg_checker
bind pllcg_top pllcg_checker u_chk (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_HSEL(I_HSEL),
   .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE),
   .I_HREADY(I_HREADY), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_HRDATA(O_HRDATA),
   .I_DEVICE_RESET_N(I_DEVICE_RESET_N), .O_CORE_CLK_EN(O_CORE_CLK_EN),
   .O_LOOP_POWER_EN(O_LOOP_POWER_EN), .O_LOCKED(O_LOCKED));
`default_nettype wire

// [pllcg_ref_model.sv]
// partner: reference clock source and mode strap pins
`timescale 1ns/1ps
`default_nettype none
module pllcg_ref_model (
   // control
   input wire logic i_clk,
   input wire logic [2:0] i_code,
   input wire logic i_dev_rst_n,
   // pins
   output logic o_ref_clk,
   output logic o_strap_a,
   output logic o_strap_b,
   output logic o_strap_c
);
   logic [3:0] hold_reg = 4'h0;
   initial begin
      o_ref_clk = 1'b0;
      #7;
      forever #100 o_ref_clk = ~o_ref_clk;
   end
   always @(posedge i_clk) begin
      if (!i_dev_rst_n) hold_reg <= 4'h0;
      else if (hold_reg != 4'hf) hold_reg <= hold_reg + 4'h1;
   end
   // valid through reset and a short hold, then wrong on purpose
   assign {o_strap_a, o_strap_b, o_strap_c} =
      (!i_dev_rst_n || hold_reg < 4'h8) ? i_code : ~i_code;
endmodule : pllcg_ref_model
`default_nettype wire

// [tb_pll_clock_mode_generator.sv]
// testbench: straps, divider rates, loop lock and register bus of the clock mode generator
`timescale 1ns/1ps
`default_nettype none
module tb_pll_clock_mode_generator;
   import pllcg_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic dev_rst_n = 1'b1;
   logic [2:0] code = 3'h0;
   logic [31:0] rd;
   wire logic hready, hresp, ref_clk, st_a, st_b, st_c, core_en, pwr_en, locked;
   wire logic [31:0] hrdata;
   int errors = 0;
   int tests_run = 0;
   int seed = 32'hab4889bc;
   int model_cfg;
   int exp_q[$];
   always #10 clk = ~clk;
   pllcg_ref_model u_ref (.i_clk(clk), .i_code(code), .i_dev_rst_n(dev_rst_n),
      .o_ref_clk(ref_clk), .o_strap_a(st_a), .o_strap_b(st_b), .o_strap_c(st_c));
   pllcg_top uut (.I_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
      .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HRDATA(hrdata),
      .I_REF_CLK(ref_clk), .I_DEVICE_RESET_N(dev_rst_n), .I_MODE_STRAP_A(st_a),
      .I_MODE_STRAP_B(st_b), .I_MODE_STRAP_C(st_c), .O_CORE_CLK_EN(core_en),
      .O_LOOP_POWER_EN(pwr_en), .O_LOCKED(locked));
   ////////////////////////////////////////
   task stop_test;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task near(input int got, input int exp, input int tol);
      tests_run++;
      if (got > exp + tol || got < exp - tol) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : near
   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : xfer
   // registered outputs are read a little after the edge
   task count_en(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (core_en === 1'b1) c++;
      end
   endtask : count_en
   task wait_lock(input logic v, output int t);
      t = 0;
      while (locked !== v && t < 2000) begin
         @(posedge clk);
         #1;
         t++;
      end
   endtask : wait_lock
   function automatic int strap_cfg(input int c);
      case (c)
         1: return 16'h9007;
         2: return 16'h4007;
         4: return 16'h1007;
         6: return 16'hf007;
         5: return 16'hf000;
         default: return 0;
      endcase
   endfunction : strap_cfg
   ////////////////////////////////////////
   initial begin
      int c;
      int t;
      int r;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         code <= k[2:0];
         dev_rst_n <= 1'b0;
         repeat (10) @(posedge clk);
         dev_rst_n <= 1'b1;
         repeat (6) @(posedge clk);
         model_cfg = strap_cfg(k);
         exp_q.push_back(model_cfg & 32'hfffe);
         xfer(PLLCG_ADDR_CLK_MODE, 1'b0, 32'h0);
         check(rd, exp_q.pop_front());
         check(pwr_en, model_cfg[2]);
         if (model_cfg[1] == 0) begin
            count_en(400, c);
            near(c, (k == 3) ? 40 : (model_cfg[15:12] == 4'hf) ? 10 : 20, 2);
         end
      end
      // each new factor restarts the lock wait set by the count field
      for (int i = 0; i < 4; i++) begin
         r = $random(seed) & 1;
         model_cfg = (i << 12) | (r << 11) | (i << 3) | 6;
         xfer(PLLCG_ADDR_CLK_MODE, 1'b1, model_cfg);
         // the old factor stays locked until its next pulse
         wait_lock(1'b0, t);
         wait_lock(1'b1, t);
         near(t, (i + 1) * 160 + 15, 40);
         xfer(PLLCG_ADDR_CLK_MODE, 1'b0, 32'h0);
         check(rd, model_cfg | 1);
         count_en(400, c);
         near(c, r ? (2 * i + 1) * 20 : (i + 1) * 40, 3);
      end
      xfer(PLLCG_ADDR_CLK_MODE, 1'b1, 32'h0);
      wait_lock(1'b0, t);
      check(locked, 1'b0);
      check(pwr_en, 1'b0);
      // device reset while locked must fall back to the strap setting
      xfer(PLLCG_ADDR_CLK_MODE, 1'b1, 32'h6);
      wait_lock(1'b1, t);
      near(t, 175, 40);
      dev_rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      check(locked, 1'b0);
      dev_rst_n <= 1'b1;
      xfer(32'h5c, 1'b1, 32'hffff);
      xfer(32'h5c, 1'b0, 32'h0);
      check(rd, 32'h0);
      xfer(PLLCG_ADDR_CLK_MODE, 1'b0, 32'h0);
      check(rd, 32'h0);
      stop_test();
   end
   initial begin
      #400000;
      errors++;
      stop_test();
   end
endmodule : tb_pll_clock_mode_generator
`default_nettype wire
